// ---- design/swst_map.vh ----
// Timing constants for the single-wire slot timing slave
`ifndef SWST_MAP_VH
`define SWST_MAP_VH
// Times in microseconds at regular speed
`define SWST_SAMPLE_US       30
`define SWST_RESET_US        480
`define SWST_READ_VALID_US   15
`define SWST_PRES_WAIT_US    30
`define SWST_PRES_LOW_US     120
// Accelerated mode divides every time by this factor
`define SWST_FAST_DIV        10
// Clock rate in cycles per microsecond
`define SWST_CYC_PER_US      250
`define SWST_CNT_W           20
`endif

// ---- design/swst_sync.v ----
// Two-flop input synchroniser for the data line
`default_nettype none
module swst_sync
(
  input  wire I_CLOCK,
  input  wire I_RST_N,
  input  wire i_d,
  output wire o_q
);
  reg s1;
  reg s2;
  // Idle line is high; reset to the released level
  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
    end
    else
    begin
      s1 <= i_d;
      s2 <= s1;
    end
  end
  assign o_q = s2;
endmodule
`default_nettype wire

// ---- design/swst_slave.v ----
// Single-wire bus slave bit timing engine
// Notes on behaviour
// - Slave restarts its slot timer on every falling edge of the line while idle or in a slot; edges during presence are ignored.
// - Write slots are sampled nominally 30 us after the falling edge.
// - Sampling lands within 15..60 us; master holds a stable level then.
// - Any low pulse of 480 us or more is a bus reset.
// - Read one leaves line alone; read zero holds it low 15 us.
// - Slave releases a zero within 0 to 45 us after valid time.
// - A detected reset overrides any slot in progress and restarts the slave.
// - After reset wait 30 us, then drive presence low for 120 us.
// - Endless low acts as reset; presence follows when line goes high.
// - Master starts every bit; slave only responds.
// - Accelerated mode scales all timing by ten; regular speed by default.
`default_nettype none
`include "swst_map.vh"
module swst_slave
#(
  parameter CYC_PER_US = `SWST_CYC_PER_US,
  parameter RESET_US   = `SWST_RESET_US
)
(
  input  wire I_CLOCK,
  input  wire I_RST_N,
  input  wire I_LINE_IN,
  output wire O_LINE_OUT,
  output wire O_LINE_OE,
  input  wire I_FAST_MODE,
  input  wire I_TX_VALID,
  input  wire I_TX_BIT,
  output wire O_TX_TAKEN,
  output reg  O_RX_VALID,
  output reg  O_RX_BIT,
  output reg  O_RESET_SEEN,
  output reg  O_PRESENCE
);
  localparam W = `SWST_CNT_W;
  // Cycle counts at regular speed
  localparam [W-1:0] C_SAMPLE = CYC_PER_US * `SWST_SAMPLE_US;
  localparam [W-1:0] C_RESET  = CYC_PER_US * RESET_US;
  localparam [W-1:0] C_RDV    = CYC_PER_US * `SWST_READ_VALID_US;
  localparam [W-1:0] C_PWAIT  = CYC_PER_US * `SWST_PRES_WAIT_US;
  localparam [W-1:0] C_PLOW   = CYC_PER_US * `SWST_PRES_LOW_US;

  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_SLOT  = 5'h02;
  localparam [4:0] S_LOWRS = 5'h04;
  localparam [4:0] S_PWAIT = 5'h08;
  localparam [4:0] S_PLOW  = 5'h10;

  // Scales a regular-speed count for accelerated mode
  function [W-1:0] scale;
    input [W-1:0] c;
    input         fast;
    begin
      if (fast)
        scale = c / `SWST_FAST_DIV;
      else
        scale = c;
      if (scale == {W{1'b0}})
        scale = {{(W-1){1'b0}}, 1'b1};
    end
  endfunction

  wire line;
  reg  line_d;
  reg  [4:0] state;
  reg  [W-1:0] cnt;
  reg  [W-1:0] low_cnt;
  reg  fast;
  reg  drive_zero;
  reg  sampled;
  // Set for a slot with no read bit offered, so only write slots report a sample
  reg  is_write;

  swst_sync u_sync
  (
    .I_CLOCK (I_CLOCK),
    .I_RST_N (I_RST_N),
    .i_d     (I_LINE_IN),
    .o_q     (line)
  );

  wire fall = line_d & ~line;
  wire rise = ~line_d & line;
  // Reset pulse: low long enough, including an endless low when unplugged
  // Counts this cycle too, so a low of exactly the reset length is caught
  wire rst_hit = ~line & (low_cnt + {{(W-1){1'b0}}, 1'b1} >= scale(C_RESET, fast));

  // Bit offered by the user is taken at each slot start; the slave never starts one
  assign O_TX_TAKEN = fall & I_TX_VALID & (state == S_IDLE || state == S_SLOT);
  assign O_LINE_OUT = 1'b0;
  assign O_LINE_OE  = drive_zero | (state == S_PLOW);

  always @(posedge I_CLOCK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      line_d       <= 1'b1;
      state        <= S_IDLE;
      cnt          <= {W{1'b0}};
      low_cnt      <= {W{1'b0}};
      fast         <= 1'b0;
      drive_zero   <= 1'b0;
      sampled      <= 1'b0;
      is_write     <= 1'b0;
      O_RX_VALID   <= 1'b0;
      O_RX_BIT     <= 1'b0;
      O_RESET_SEEN <= 1'b0;
      O_PRESENCE   <= 1'b0;
    end
    else
    begin
      line_d       <= line;
      O_RX_VALID   <= 1'b0;
      O_RESET_SEEN <= 1'b0;
      if (line)
        low_cnt <= {W{1'b0}};
      else if (low_cnt != {W{1'b1}})
        low_cnt <= low_cnt + {{(W-1){1'b0}}, 1'b1};
      if (rst_hit && state != S_LOWRS)
      begin
        // Reset overrides any slot, releases the line, drops back to regular speed
        state        <= S_LOWRS;
        drive_zero   <= 1'b0;
        O_PRESENCE   <= 1'b0;
        O_RESET_SEEN <= 1'b1;
        fast         <= 1'b0;
      end
      else
      begin
        case (state)
          S_IDLE, S_SLOT:
          begin
            if (fall)
            begin
              // Resynchronise on every falling edge
              state      <= S_SLOT;
              cnt        <= {W{1'b0}};
              sampled    <= 1'b0;
              is_write   <= ~I_TX_VALID;
              drive_zero <= I_TX_VALID & ~I_TX_BIT;
            end
            else if (state == S_SLOT)
            begin
              cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
              // Read zero held for the valid time, released at once after it
              if (cnt + {{(W-1){1'b0}}, 1'b1} >= scale(C_RDV, fast))
                drive_zero <= 1'b0;
              // Mid-slot sample of the master's bit
              if (!sampled && cnt + {{(W-1){1'b0}}, 1'b1} == scale(C_SAMPLE, fast))
              begin
                sampled    <= 1'b1;
                O_RX_VALID <= is_write;
                if (is_write)
                  O_RX_BIT <= line;
                state      <= S_IDLE;
              end
            end
          end
          S_LOWRS:
            if (rise)
            begin
              // Presence follows the end of any reset low
              state <= S_PWAIT;
              cnt   <= {W{1'b0}};
              fast  <= I_FAST_MODE;
            end
          S_PWAIT:
          begin
            cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
            if (cnt + {{(W-1){1'b0}}, 1'b1} >= scale(C_PWAIT, fast))
            begin
              state      <= S_PLOW;
              cnt        <= {W{1'b0}};
              O_PRESENCE <= 1'b1;
            end
          end
          S_PLOW:
          begin
            cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
            if (cnt + {{(W-1){1'b0}}, 1'b1} >= scale(C_PLOW, fast))
            begin
              state      <= S_IDLE;
              O_PRESENCE <= 1'b0;
            end
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/swst_slave_assertions.sv ----
// Port checks for the slot timing slave
`default_nettype none
module swst_slave_chk (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic I_LINE_IN,
  input wire logic O_LINE_OUT,
  input wire logic O_LINE_OE,
  input wire logic I_TX_VALID,
  input wire logic I_TX_BIT,
  input wire logic O_TX_TAKEN,
  input wire logic O_RX_VALID,
  input wire logic O_RX_BIT,
  input wire logic O_RESET_SEEN,
  input wire logic O_PRESENCE
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  open_drain_a: assert property (O_LINE_OUT == 1'b0)
    else $error("line value not low");
  pres_drive_a: assert property (O_PRESENCE |-> O_LINE_OE)
    else $error("presence not driven");
  pres_width_a: assert property ($rose(O_PRESENCE) |=> O_PRESENCE [*8])
    else $error("presence too short");
  pres_wait_a: assert property (O_RESET_SEEN |=> !O_PRESENCE [*8])
    else $error("presence too early");
  reset_low_a: assert property (O_RESET_SEEN |-> !$past(I_LINE_IN, 4))
    else $error("reset without low line");
  rx_hold_a: assert property (!O_RX_VALID |-> $stable(O_RX_BIT))
    else $error("sampled bit moved");
  take_offer_a: assert property (O_TX_TAKEN |-> I_TX_VALID)
    else $error("bit taken unoffered");
  zero_pull_a: assert property (O_TX_TAKEN && !I_TX_BIT |=> O_LINE_OE [*8])
    else $error("read zero not held");
endmodule
bind swst_slave swst_slave_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N),
  .I_LINE_IN(I_LINE_IN), .O_LINE_OUT(O_LINE_OUT), .O_LINE_OE(O_LINE_OE),
  .I_TX_VALID(I_TX_VALID), .I_TX_BIT(I_TX_BIT), .O_TX_TAKEN(O_TX_TAKEN),
  .O_RX_VALID(O_RX_VALID), .O_RX_BIT(O_RX_BIT), .O_RESET_SEEN(O_RESET_SEEN),
  .O_PRESENCE(O_PRESENCE));
`default_nettype wire

// ---- test/swst_master.sv ----
// Bus master model pulling the shared line
`default_nettype none
module swst_master (
  input  wire logic clk,
  input  wire logic line,
  output var  logic m_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial m_oe = 1'b0;
  // Slot with 20 cycles recovery; released line rises by pull-up
  task automatic slot(input int low, input int act, input int smp, output logic got);
    got = 1'b1;
    for (int i = 0; i < act + 20; i++)
    begin
      @(negedge clk);
      m_oe <= (i < low);
      if (i == smp)
        got = line;
    end
  endtask
  task automatic rst(output int pres);
    pres = 0;
    for (int i = 0; i < 19200; i++)
    begin
      @(negedge clk);
      m_oe <= (i < 9600);
      if (i > 9600 && !line)
        pres++;
    end
  endtask
endmodule
`default_nettype wire

// ---- test/swst_slave_bench.sv ----
// Self-checking bench for the slot timing slave
`default_nettype none
module swst_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, fast = 1'b0, tx_v = 1'b0, tx_b = 1'b0;
  logic m_oe, oe, drv, taken, rx_v, rx_b, seen, pres, got;
  wire line = !(m_oe | oe);
  int num_errors = 0, checks_done = 0, n_rx = 0, n_rst = 0, n_tk = 0, plen;
  // Row is read request, bit, expected sample count
  logic [2:0] rows [4] = '{3'b001, 3'b011, 3'b100, 3'b110};
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    n_rx <= n_rx + rx_v;
    n_rst <= n_rst + seen;
    n_tk <= n_tk + taken;
  end
  swst_slave #(.CYC_PER_US(20), .RESET_US(480)) DUT (.I_CLOCK(clk), .I_RST_N(rst_n),
    .I_LINE_IN(line), .O_LINE_OUT(drv), .O_LINE_OE(oe), .I_FAST_MODE(fast),
    .I_TX_VALID(tx_v), .I_TX_BIT(tx_b), .O_TX_TAKEN(taken), .O_RX_VALID(rx_v),
    .O_RX_BIT(rx_b), .O_RESET_SEEN(seen), .O_PRESENCE(pres));
  swst_master MST (.clk(clk), .line(line), .m_oe(m_oe));
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    int d, p, q;
    repeat (20) @(negedge clk);
    chk("oe", oe, 0);
    chk("line out", drv, 0);
    rst_n = 1'b1;
    $display("test reset done");
    for (int f = 0; f < 2; f++)
    begin
      d = f ? 10 : 1;
      fast = f[0];
      // A read zero is pending when the reset strikes
      tx_v = 1'b1;
      tx_b = 1'b0;
      p = n_rst;
      MST.rst(plen);
      chk("resets", 16'(n_rst - p), 1);
      chk("presence", 16'(plen), 16'(2400 / d));
      foreach (rows[r])
      begin
        {tx_v, tx_b} = rows[r][2:1];
        p = n_rx;
        q = n_tk;
        MST.slot(tx_v ? 20 : tx_b ? (f ? 20 : 40) : 1400 / d, 1600 / d, f ? 26 : 260, got);
        chk("rx count", 16'(n_rx - p), rows[r][0]);
        chk("taken", 16'(n_tk - q), tx_v);
        if (tx_v)
          chk("read bit", got, tx_b);
        else
          chk("rx bit", rx_b, tx_b);
      end
      $display("test speed %0d done", f);
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
